// ==== common/lcad_core_if.sv ====
// Carrier between the controller, the arithmetic unit and the pointer file.
// Assumes all three sit on the same clock.
`timescale 1ns/1ps
interface lcad_core_if;
    lcad_pkg::lcad_alu_op_e alu_op;
    logic [lcad_pkg::DATA_W-1:0] alu_a;
    logic [lcad_pkg::DATA_W-1:0] alu_b;
    logic alu_cin;
    logic [lcad_pkg::DATA_W-1:0] alu_y;
    logic alu_c;
    logic alu_nib;
    logic alu_z;
    logic ptr_wr_en;
    logic ptr_wr_sel;
    logic [lcad_pkg::PTR_W-1:0] ptr_wr_data;
    logic ptr_add_en;
    logic ptr_add_sel;
    logic [lcad_pkg::PTR_K_W-1:0] ptr_add_k;
    logic [lcad_pkg::PTR_W-1:0] ptr0;
    logic [lcad_pkg::PTR_W-1:0] ptr1;
    modport alu (input alu_op, alu_a, alu_b, alu_cin, output alu_y, alu_c, alu_nib, alu_z);
    modport ptr (input ptr_wr_en, ptr_wr_sel, ptr_wr_data, ptr_add_en, ptr_add_sel, ptr_add_k,
                 output ptr0, ptr1);
    modport ctrl (output alu_op, alu_a, alu_b, alu_cin, ptr_wr_en, ptr_wr_sel, ptr_wr_data,
                  ptr_add_en, ptr_add_sel, ptr_add_k,
                  input alu_y, alu_c, alu_nib, alu_z, ptr0, ptr1);
endinterface : lcad_core_if

// ==== common/lcad_pkg.sv ====
// Constants, opcodes, register map and types for the literal/control decoder.
// Assumes a 14-bit instruction word and an 8-bit data path.
package lcad_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned INSTR_W = 14;
    localparam int unsigned FADDR_W = 7;
    localparam int unsigned PTR_W = 16;
    localparam int unsigned PTR_K_W = 6;
    localparam int unsigned PC_W = 15;
    localparam int unsigned BANK_W = 5;
    localparam int unsigned PAGE_W = 7;
    localparam int unsigned PADDR_W = 8;
    localparam int unsigned CYC_W = 4;

    // Register byte offsets
    localparam logic [7:0] REG_INSTR = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_ACC = 8'h08;
    localparam logic [7:0] REG_BANK = 8'h0c;
    localparam logic [7:0] REG_PAGE = 8'h10;
    localparam logic [7:0] REG_PTR0 = 8'h14;
    localparam logic [7:0] REG_PTR1 = 8'h18;

    // Status field positions
    localparam int unsigned ST_MSB_SPILL = 0;
    localparam int unsigned ST_NIBBLE_SPILL = 1;
    localparam int unsigned ST_NULL_RESULT = 2;
    localparam int unsigned ST_BUSY = 8;
    localparam int unsigned ST_ILLEGAL = 9;
    localparam int unsigned ST_CYC_LO = 16;

    // Reset values
    localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
    localparam logic [BANK_W-1:0] BANK_RST = 5'h00;
    localparam logic [PAGE_W-1:0] PAGE_RST = 7'h00;
    localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
    localparam logic [INSTR_W-1:0] INSTR_RST = 14'h0000;

    // File addresses of the two indirect data ports
    localparam logic [FADDR_W-1:0] IND0_ADDR = 7'h00;
    localparam logic [FADDR_W-1:0] IND1_ADDR = 7'h01;

    // Opcode fields
    localparam logic [5:0] OPC_FILE_ADD = 6'h07;
    localparam logic [5:0] OPC_FILE_AND = 6'h05;
    localparam logic [5:0] OPC_FILE_ADDC = 6'h3d;
    localparam logic [3:0] OPC_SKIP0 = 4'h6;
    localparam logic [3:0] OPC_SKIP1 = 4'h7;
    localparam logic [5:0] OPC_ADDL = 6'h3e;
    localparam logic [5:0] OPC_ANDL = 6'h39;
    localparam logic [5:0] OPC_ORL = 6'h38;
    localparam logic [5:0] OPC_XORL = 6'h3a;
    localparam logic [5:0] OPC_SUBL = 6'h3c;
    localparam logic [5:0] OPC_MOVL = 6'h30;
    localparam logic [8:0] OPC_BANKL = 9'h001;
    localparam logic [6:0] OPC_PAGEL = 7'h63;
    localparam logic [6:0] OPC_PTRADD = 7'h62;
    localparam logic [4:0] OPC_RELJ = 5'h19;
    localparam logic [2:0] OPC_CALL = 3'h4;
    localparam logic [2:0] OPC_JUMP = 3'h5;
    localparam logic [13:0] OPC_ACCJ = 14'h000b;
    localparam logic [13:0] OPC_ACCCALL = 14'h000a;

    typedef enum logic [2:0] {
        LCAD_ADD = 3'h0,
        LCAD_ADDC = 3'h1,
        LCAD_SUB = 3'h2,
        LCAD_AND = 3'h3,
        LCAD_OR = 3'h4,
        LCAD_XOR = 3'h5,
        LCAD_PASS = 3'h6
    } lcad_alu_op_e;

    typedef enum logic [4:0] {
        LCAD_IDLE = 5'b00001,
        LCAD_READ = 5'b00010,
        LCAD_EXEC = 5'b00100,
        LCAD_EXTRA = 5'b01000,
        LCAD_NOP = 5'b10000
    } lcad_state_e;
endpackage : lcad_pkg

// ==== src/lcad_alu.sv ====
// Combinational 8-bit arithmetic and logic unit with spill flags.
// Assumes the controller decides which flags are kept.
`timescale 1ns/1ps
module lcad_alu (
    lcad_core_if.alu bus
);
    wire is_sub = (bus.alu_op == lcad_pkg::LCAD_SUB);
    // Subtract as a + ~b + 1 so the spills read as no-borrow
    wire [7:0] addend = is_sub ? ~bus.alu_b : bus.alu_b;
    wire carry = (bus.alu_op == lcad_pkg::LCAD_ADDC) ? bus.alu_cin : is_sub;
    wire [8:0] sum = {1'b0, bus.alu_a} + {1'b0, addend} + {8'h00, carry};
    wire [4:0] low_sum = {1'b0, bus.alu_a[3:0]} + {1'b0, addend[3:0]} + {4'h0, carry};
    logic [7:0] result;

    always_comb begin
        unique case (bus.alu_op)
            lcad_pkg::LCAD_ADD, lcad_pkg::LCAD_ADDC, lcad_pkg::LCAD_SUB: result = sum[7:0];
            lcad_pkg::LCAD_AND: result = bus.alu_a & bus.alu_b;
            lcad_pkg::LCAD_OR: result = bus.alu_a | bus.alu_b;
            lcad_pkg::LCAD_XOR: result = bus.alu_a ^ bus.alu_b;
            default: result = bus.alu_a;
        endcase
    end

    assign bus.alu_y = result;
    assign bus.alu_c = sum[8];
    assign bus.alu_nib = low_sum[4];
    assign bus.alu_z = (result == 8'h00);
endmodule : lcad_alu

// ==== src/lcad_ptr.sv ====
// Indirect pointer pair with offset add and software load.
// Assumes load and add never target the same pointer in one cycle.
`timescale 1ns/1ps
module lcad_ptr #(
    parameter int unsigned PTR_COUNT = 2
) (
    input wire logic sys_clk,
    input wire logic reset,
    lcad_core_if.ptr bus
);
    if (PTR_COUNT != 2) begin : g_bad_count
        $error("lcad_ptr: one select bit serves exactly two pointers");
    end

    logic [lcad_pkg::PTR_W-1:0] ptr [PTR_COUNT];
    wire [lcad_pkg::PTR_W-1:0] offset = {{10{bus.ptr_add_k[5]}}, bus.ptr_add_k};

    for (genvar i = 0; i < PTR_COUNT; i++) begin : g_ptr
        wire hit_wr = bus.ptr_wr_en && (bus.ptr_wr_sel == i[0]);
        wire hit_add = bus.ptr_add_en && (bus.ptr_add_sel == i[0]);
        always_ff @(posedge sys_clk) begin
            if (reset) begin
                ptr[i] <= lcad_pkg::PTR_RST;
            end else if (hit_wr) begin
                ptr[i] <= bus.ptr_wr_data;
            end else if (hit_add) begin
                // 16-bit sum wraps on its own
                ptr[i] <= ptr[i] + offset;
            end
        end
    end

    assign bus.ptr0 = ptr[0];
    assign bus.ptr1 = ptr[1];
endmodule : lcad_ptr

// ==== src/lcad_top.sv ====
// Decode and execute unit for literal, control, skip and file AND/ADD operations.
// Assumes an APB master, a file memory answering file_rd in the same cycle,
// and a program counter and stack outside that follow pc_strobe and stack_push.
// Functional notes
// - Literal add puts W plus the 8-bit literal in W and updates all three arithmetic flags.
// - Literal AND puts W AND literal in W and changes only the zero flag.
// - File AND combines W with the file register, destination bit picks W or file, zero only.
// - File add sums W and a file register 0..127 to W or file and updates all three flags.
// - Pointer offset add adds a signed 6-bit literal to pointer 0 or 1 with no flag change.
// - The pointer sum wraps modulo 16 bits at both ends.
// - A PC change or a true condition takes two cycles, the second being a no-operation.
// - A file operation on an indirect port whose pointer has its top bit set adds one cycle.
// - Bit-test skips skip the next instruction on clear or set, taking two cycles when so.
// - Literal move loads W without flags; literal minus W goes to W with all three flags.
// - Literal OR and XOR go to W and change only the zero flag.
// - Relative jumps add a literal or W to the PC and take two cycles.
// - Calls push the return address and jump to a literal or W-based target in two cycles.
// - Absolute jump loads the PC from the literal plus page latch bits in two cycles.
// - File add with carry sums W, the carry flag and the file register, all three flags.
`timescale 1ns/1ps
module lcad_top (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [lcad_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [lcad_pkg::FADDR_W-1:0] file_addr,
    output logic file_rd,
    input wire logic [lcad_pkg::DATA_W-1:0] file_rdata,
    output logic file_we,
    output logic [lcad_pkg::DATA_W-1:0] file_wdata,
    output logic pc_strobe,
    output logic pc_relative,
    output logic [lcad_pkg::PC_W-1:0] pc_value,
    output logic stack_push,
    output logic skip_next,
    output logic [lcad_pkg::BANK_W-1:0] bank_select_reg,
    output logic [lcad_pkg::PAGE_W-1:0] program_page_latch,
    output logic busy
);
    lcad_core_if core ();
    lcad_pkg::lcad_state_e state;
    lcad_pkg::lcad_state_e next_state;

    logic [lcad_pkg::INSTR_W-1:0] ir;
    logic [lcad_pkg::DATA_W-1:0] acc;
    logic [lcad_pkg::DATA_W-1:0] fval;
    logic msb_spill_flag;
    logic nibble_spill_flag;
    logic null_result_flag;
    logic illegal_flag;
    logic [lcad_pkg::CYC_W-1:0] cyc_cnt;
    logic [lcad_pkg::CYC_W-1:0] last_cycles;

    // Bus decode
    wire setup = psel && !penable;
    wire access = psel && penable;
    wire idle = (state == lcad_pkg::LCAD_IDLE);
    wire hit_instr = (paddr == lcad_pkg::REG_INSTR);
    wire hit_status = (paddr == lcad_pkg::REG_STATUS);
    wire hit_acc = (paddr == lcad_pkg::REG_ACC);
    wire hit_bank = (paddr == lcad_pkg::REG_BANK);
    wire hit_page = (paddr == lcad_pkg::REG_PAGE);
    wire hit_ptr0 = (paddr == lcad_pkg::REG_PTR0);
    wire hit_ptr1 = (paddr == lcad_pkg::REG_PTR1);
    wire mapped = hit_instr | hit_status | hit_acc | hit_bank | hit_page | hit_ptr0 | hit_ptr1;
    // Writes only land while idle so software never races the executing instruction
    wire wr_ok = access && pwrite && mapped && idle;
    wire start = wr_ok && hit_instr;

    // Instruction decode
    wire [5:0] op6 = ir[13:8];
    wire is_fadd = (op6 == lcad_pkg::OPC_FILE_ADD);
    wire is_fand = (op6 == lcad_pkg::OPC_FILE_AND);
    wire is_faddc = (op6 == lcad_pkg::OPC_FILE_ADDC);
    wire is_skip0 = (ir[13:10] == lcad_pkg::OPC_SKIP0);
    wire is_skip1 = (ir[13:10] == lcad_pkg::OPC_SKIP1);
    wire is_addl = (op6 == lcad_pkg::OPC_ADDL);
    wire is_andl = (op6 == lcad_pkg::OPC_ANDL);
    wire is_orl = (op6 == lcad_pkg::OPC_ORL);
    wire is_xorl = (op6 == lcad_pkg::OPC_XORL);
    wire is_subl = (op6 == lcad_pkg::OPC_SUBL);
    wire is_movl = (op6 == lcad_pkg::OPC_MOVL);
    wire is_bankl = (ir[13:5] == lcad_pkg::OPC_BANKL);
    wire is_pagel = (ir[13:7] == lcad_pkg::OPC_PAGEL);
    wire is_ptradd = (ir[13:7] == lcad_pkg::OPC_PTRADD);
    wire is_relj = (ir[13:9] == lcad_pkg::OPC_RELJ);
    wire is_accj = (ir == lcad_pkg::OPC_ACCJ);
    wire is_call = (ir[13:11] == lcad_pkg::OPC_CALL);
    wire is_accc = (ir == lcad_pkg::OPC_ACCCALL);
    wire is_jump = (ir[13:11] == lcad_pkg::OPC_JUMP);

    wire file_math = is_fadd | is_fand | is_faddc;
    wire file_op = file_math | is_skip0 | is_skip1;
    wire lit_math = is_addl | is_andl | is_orl | is_xorl | is_subl | is_movl;
    wire pc_op = is_relj | is_accj | is_call | is_accc | is_jump;
    wire known = file_op | lit_math | is_bankl | is_pagel | is_ptradd | pc_op;
    wire [lcad_pkg::FADDR_W-1:0] f_addr = ir[6:0];
    wire to_file = ir[7];
    wire [2:0] bit_sel = ir[9:7];
    wire [lcad_pkg::DATA_W-1:0] lit = ir[7:0];

    // skip condition from the tested bit
    wire tested_bit = fval[bit_sel];
    wire skip_true = (is_skip0 && !tested_bit) || (is_skip1 && tested_bit);
    // PC change or true test needs the dead cycle
    wire two_cycle = pc_op | skip_true;
    // indirect access through a pointer with its top bit set
    wire ind_slow = file_op && (((f_addr == lcad_pkg::IND0_ADDR) && core.ptr0[15]) ||
                                ((f_addr == lcad_pkg::IND1_ADDR) && core.ptr1[15]));

    // Flag classes
    wire arith = is_addl | is_subl | is_fadd | is_faddc;
    wire zero_only = is_andl | is_orl | is_xorl | is_fand;
    wire acc_dest = lit_math | (file_math && !to_file);
    wire exec = (state == lcad_pkg::LCAD_EXEC);

    // Operand steering into the arithmetic unit
    always_comb begin
        core.alu_op = lcad_pkg::LCAD_PASS;
        core.alu_a = acc;
        core.alu_b = file_math ? fval : lit;
        core.alu_cin = msb_spill_flag;
        if (is_addl || is_fadd) begin
            core.alu_op = lcad_pkg::LCAD_ADD;
        end else if (is_faddc) begin
            core.alu_op = lcad_pkg::LCAD_ADDC;
        end else if (is_subl) begin
            core.alu_op = lcad_pkg::LCAD_SUB;
            core.alu_a = lit;
            core.alu_b = acc;
        end else if (is_andl || is_fand) begin
            core.alu_op = lcad_pkg::LCAD_AND;
        end else if (is_orl) begin
            core.alu_op = lcad_pkg::LCAD_OR;
        end else if (is_xorl) begin
            core.alu_op = lcad_pkg::LCAD_XOR;
        end else if (is_movl) begin
            core.alu_a = lit;
        end
    end

    lcad_alu u_alu (
        .bus(core)
    );

    // offset add steered to the chosen pointer
    assign core.ptr_add_en = exec && is_ptradd;
    assign core.ptr_add_sel = ir[6];
    assign core.ptr_add_k = ir[5:0];
    assign core.ptr_wr_en = wr_ok && (hit_ptr0 || hit_ptr1);
    assign core.ptr_wr_sel = hit_ptr1;
    assign core.ptr_wr_data = pwdata[15:0];

    lcad_ptr #(
        .PTR_COUNT(2)
    ) u_ptr (
        .sys_clk(sys_clk),
        .reset(reset),
        .bus(core)
    );

    // Sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            lcad_pkg::LCAD_IDLE: begin
                if (start) begin
                    next_state = lcad_pkg::LCAD_READ;
                end
            end
            lcad_pkg::LCAD_READ: next_state = lcad_pkg::LCAD_EXEC;
            lcad_pkg::LCAD_EXEC: begin
                // extra cycle first, then any dead cycle
                if (ind_slow) begin
                    next_state = lcad_pkg::LCAD_EXTRA;
                end else if (two_cycle) begin
                    next_state = lcad_pkg::LCAD_NOP;
                end else begin
                    next_state = lcad_pkg::LCAD_IDLE;
                end
            end
            lcad_pkg::LCAD_EXTRA: begin
                next_state = two_cycle ? lcad_pkg::LCAD_NOP : lcad_pkg::LCAD_IDLE;
            end
            lcad_pkg::LCAD_NOP: next_state = lcad_pkg::LCAD_IDLE;
            default: next_state = lcad_pkg::LCAD_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= lcad_pkg::LCAD_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ir <= lcad_pkg::INSTR_RST;
            fval <= 8'h00;
        end else if (start) begin
            ir <= pwdata[13:0];
        end else if (state == lcad_pkg::LCAD_READ) begin
            fval <= file_op ? file_rdata : 8'h00;
        end
    end

    // Instruction cycles counted in execute, extra and dead cycles
    wire counting = exec || (state == lcad_pkg::LCAD_EXTRA) || (state == lcad_pkg::LCAD_NOP);
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cyc_cnt <= 4'h0;
            last_cycles <= 4'h0;
        end else if (start) begin
            cyc_cnt <= 4'h0;
        end else if (counting) begin
            cyc_cnt <= cyc_cnt + 4'h1;
            if (next_state == lcad_pkg::LCAD_IDLE) begin
                last_cycles <= cyc_cnt + 4'h1;
            end
        end
    end

    // Accumulator
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            acc <= lcad_pkg::ACC_RST;
        end else if (exec && acc_dest) begin
            // destination bit 0 sends the result to W
            acc <= core.alu_y;
        end else if (wr_ok && hit_acc) begin
            acc <= pwdata[7:0];
        end
    end

    // Status flags
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            msb_spill_flag <= 1'b0;
            nibble_spill_flag <= 1'b0;
            null_result_flag <= 1'b0;
            illegal_flag <= 1'b0;
        end else if (exec) begin
            if (arith) begin
                msb_spill_flag <= core.alu_c;
                nibble_spill_flag <= core.alu_nib;
                null_result_flag <= core.alu_z;
            end else if (zero_only) begin
                // zero flag alone for logic forms
                null_result_flag <= core.alu_z;
            end
            illegal_flag <= !known;
        end else if (wr_ok && hit_status) begin
            msb_spill_flag <= pwdata[lcad_pkg::ST_MSB_SPILL];
            nibble_spill_flag <= pwdata[lcad_pkg::ST_NIBBLE_SPILL];
            null_result_flag <= pwdata[lcad_pkg::ST_NULL_RESULT];
            illegal_flag <= pwdata[lcad_pkg::ST_ILLEGAL];
        end
    end

    // Bank and page latches
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bank_select_reg <= lcad_pkg::BANK_RST;
            program_page_latch <= lcad_pkg::PAGE_RST;
        end else begin
            if (exec && is_bankl) begin
                bank_select_reg <= ir[4:0];
            end else if (wr_ok && hit_bank) begin
                bank_select_reg <= pwdata[4:0];
            end
            if (exec && is_pagel) begin
                program_page_latch <= ir[6:0];
            end else if (wr_ok && hit_page) begin
                program_page_latch <= pwdata[6:0];
            end
        end
    end

    // Program counter requests
    wire [lcad_pkg::PC_W-1:0] rel_lit = {{6{ir[8]}}, ir[8:0]};
    wire [lcad_pkg::PC_W-1:0] rel_acc = {7'h00, acc};
    wire [lcad_pkg::PC_W-1:0] abs_lit = {program_page_latch[6:3], ir[10:0]};
    wire [lcad_pkg::PC_W-1:0] abs_acc = {program_page_latch, acc};
    wire [lcad_pkg::PC_W-1:0] next_pc_value = is_relj ? rel_lit :
                                              is_accj ? rel_acc :
                                              is_accc ? abs_acc : abs_lit;

    // One-cycle pulses after the execute cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pc_strobe <= 1'b0;
            pc_relative <= 1'b0;
            pc_value <= 15'h0000;
            stack_push <= 1'b0;
            skip_next <= 1'b0;
            file_we <= 1'b0;
            file_wdata <= 8'h00;
        end else begin
            pc_strobe <= exec && pc_op;
            pc_relative <= exec && (is_relj || is_accj);
            stack_push <= exec && (is_call || is_accc);
            skip_next <= exec && skip_true;
            // destination bit 1 writes the file register
            file_we <= exec && file_math && to_file;
            if (exec) begin
                pc_value <= next_pc_value;
                file_wdata <= core.alu_y;
            end
        end
    end

    // Read mux, sampled in the setup phase so the data leaves a flop
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_instr) begin
            rd_mux = {18'h00000, ir};
        end else if (hit_status) begin
            rd_mux = {12'h000, last_cycles, 6'h00, illegal_flag, !idle, 5'h00,
                      null_result_flag, nibble_spill_flag, msb_spill_flag};
        end else if (hit_acc) begin
            rd_mux = {24'h000000, acc};
        end else if (hit_bank) begin
            rd_mux = {27'h0000000, bank_select_reg};
        end else if (hit_page) begin
            rd_mux = {25'h0000000, program_page_latch};
        end else if (hit_ptr0) begin
            rd_mux = {16'h0000, core.ptr0};
        end else if (hit_ptr1) begin
            rd_mux = {16'h0000, core.ptr1};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= rd_mux;
        end
    end

    assign pready = 1'b1;
    // Unmapped address, or a write while an instruction runs
    assign pslverr = access && (!mapped || (pwrite && !idle));
    assign file_addr = f_addr;
    assign file_rd = (state == lcad_pkg::LCAD_READ) && file_op;
    assign busy = !idle;
endmodule : lcad_top

// ==== tb/lcad_top_sva.sv ====
// Checker on lcad_top ports: pulse pairing, busy spans, file access order.
// Assumes one clock domain with the synchronous active-high reset.
`timescale 1ns/1ps
module lcad_top_sva (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic file_rd,
    input wire logic file_we,
    input wire logic pc_strobe,
    input wire logic pc_relative,
    input wire logic stack_push,
    input wire logic skip_next,
    input wire logic busy
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    a_call_push: assert property (stack_push |-> pc_strobe && !pc_relative)
        else $error("push without pc load");
    a_rel_strobe: assert property (pc_relative |-> pc_strobe && !stack_push)
        else $error("relative flag without strobe");
    a_jump_nop: assert property (pc_strobe |-> busy ##1 !busy)
        else $error("pc change not ended by one nop");
    a_skip_nop: assert property (skip_next |-> busy ##[1:2] !busy)
        else $error("skip span wrong");
    a_pc_once: assert property (pc_strobe |=> !pc_strobe)
        else $error("pc strobe longer than one cycle");
    a_we_after_rd: assert property (file_we |-> $past(file_rd, 2))
        else $error("file write without prior read");
    a_rd_exec: assert property (file_rd |-> busy ##1 busy)
        else $error("read not followed by execute");
    a_busy_ends: assert property (busy |-> ##[1:4] !busy)
        else $error("instruction too long");
endmodule : lcad_top_sva
bind lcad_top lcad_top_sva u_sva (.sys_clk(sys_clk), .reset(reset), .file_rd(file_rd),
    .file_we(file_we), .pc_strobe(pc_strobe), .pc_relative(pc_relative),
    .stack_push(stack_push), .skip_next(skip_next), .busy(busy));

// ==== tb/test_literal_control_alu_decode.sv ====
// Bench for lcad_top: APB master, file data source, pc pulse monitor.
// Assumes lcad_pkg and the bound checker are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_literal_control_alu_decode;
    logic sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, err, pcr, psh;
    logic [7:0] paddr = 0, file_rdata = 0, file_wdata;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, pc_strobe, pc_relative, stack_push, skip_next, busy, file_we;
    logic [14:0] pc_value;
    logic [4:0] bank_select_reg;
    logic [6:0] program_page_latch, file_addr;
    int n_mismatch = 0, compares = 0, pcs = 0, sk = 0, fw = 0, n, m;
    always #2 sys_clk = ~sys_clk;
    lcad_top DUT (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .file_addr, .file_rd(), .file_rdata, .file_we, .file_wdata,
        .pc_strobe, .pc_relative, .pc_value, .stack_push, .skip_next, .bank_select_reg,
        .program_page_latch, .busy);
    // Pulses stand one cycle, so latch them here
    always @(posedge sys_clk) begin
        sk += skip_next;
        fw += file_we;
        if (pc_strobe) {pcr, psh, pcs} = {pc_relative, stack_push, pcs + 1};
    end
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, ad, d};
        @(posedge sys_clk);
        penable <= 1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(posedge sys_clk);
    endtask : apb
    task automatic ex(input logic [13:0] i);
        apb(1, lcad_pkg::REG_INSTR, {18'h0, i});
        while (busy !== 1'b0) @(posedge sys_clk);
        apb(0, lcad_pkg::REG_STATUS, 0);
    endtask : ex
    task automatic t_lit;
        logic [13:0] li[8] = '{14'h300f, 14'h3ef1, 14'h39ff, 14'h385a, 14'h3a5a, 14'h3080,
            14'h3c05, 14'h3e7b};
        logic [10:0] le[8] = '{11'h00f, 11'h700, 11'h700, 11'h35a, 11'h700, 11'h780,
            11'h285, 11'h700};
        foreach (li[j]) begin
            ex(li[j]);
            `CHK("flags", le[j][10:8], rd[2:0])
            apb(0, lcad_pkg::REG_ACC, 0);
            `CHK("acc", le[j][7:0], rd[7:0])
        end
        $display("lit done");
    endtask : t_lit
    task automatic t_file;
        ex(14'h3088);
        file_rdata <= 8'h88;
        ex(14'h07a0);
        `CHK("flags_wdata", 11'h310, {rd[2:0], file_wdata})
        `CHK("addr_we", 8'h41, {file_addr, fw == 1})
        ex(14'h3d20);
        apb(0, lcad_pkg::REG_ACC, 0);
        `CHK("acc", 8'h11, rd[7:0])
        file_rdata <= 8'h00;
        ex(14'h0520);
        `CHK("flags", 3'b111, rd[2:0])
        `CHK("we", 1, fw)
        $display("file done");
    endtask : t_file
    task automatic t_ptr;
        apb(1, lcad_pkg::REG_PTR0, 1);
        apb(1, lcad_pkg::REG_PTR1, 32'hfff0);
        ex(14'h313e);
        ex(14'h315f);
        `CHK("flags", 3'b111, rd[2:0])
        apb(0, lcad_pkg::REG_PTR0, 0);
        `CHK("ptr0", 16'hffff, rd[15:0])
        apb(0, lcad_pkg::REG_PTR1, 0);
        `CHK("ptr1", 16'h000f, rd[15:0])
        ex(14'h0500);
        `CHK("cycles", 4'h2, rd[19:16])
        ex(14'h0501);
        `CHK("cycles", 4'h1, rd[19:16])
        ex(14'h3f00);
        `CHK("illegal", 5'h11, {rd[9], rd[19:16]})
        apb(0, 8'h1c, 0);
        `CHK("unmapped", 33'h100000000, {err, rd})
        $display("ptr done");
    endtask : t_ptr
    task automatic t_ctrl;
        logic [13:0] ci[8] = '{14'h2923, 14'h2123, 14'h33fe, 14'h000b, 14'h000a, 14'h1920,
            14'h1d20, 14'h1820};
        logic [22:0] ce[8] = '{23'h445123, 23'h44d123, 23'h457ffe, 23'h45003c, 23'h44d53c,
            23'h020000, 23'h240000, 23'h240000};
        ex(14'h31d5);
        ex(14'h0033);
        `CHK("bank_page", 12'h9d5, {bank_select_reg, program_page_latch})
        ex(14'h303c);
        file_rdata <= 8'h04;
        foreach (ci[j]) begin
            {n, m} = {pcs, sk};
            ex(ci[j]);
            `CHK("steps", ce[j][22:17], {pcs == n + 1, sk == m + 1, rd[19:16]})
            if (j < 5) `CHK("pc", ce[j][16:0], {pcr, psh, pc_value})
        end
        $display("ctrl done");
    endtask : t_ctrl
    task wrap_up;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (2) @(posedge sys_clk);
        reset <= 0;
        @(posedge sys_clk);
        t_lit;
        t_file;
        t_ptr;
        t_ctrl;
        wrap_up;
    end
    initial begin
        #20000;
        n_mismatch++;
        wrap_up;
    end
endmodule : test_literal_control_alu_decode
